// ---- core/timer_waveform_modes.sv ----
// Purpose: counter, compare and waveform logic of an 8-bit timer
// Assumes: timer_tick_i is the prescaled timer clock as an enable
// Notes: compare writes are buffered in the pwm modes only
`timescale 1ns/1ps

// Functional notes
// R1 - action zero leaves wave latch untouched
// R2 - new action at next match; force immediate
// R3 - mode 0 counts up, wraps FF to 00
// R4 - normal overflow flag set as count hits zero
// R5 - mode 2 clears counter on compare A
// R6 - unbuffered compare A below count wraps first
// R7 - match flag A set at each compare A match
// R8 - clear-on-match toggle A per match
// R9 - clear-on-match overflow on max to zero
// R10 - modes 3/7 single slope, top FF or A
// R11 - fast pwm overflow flag at top
// R12 - fast pwm clear on match, set at top
// R13 - toggle option only channel A, top bit
// R14 - fast pwm full period 256 ticks
// R15 - fast pwm spike at bottom, constant at max
// R16 - modes 1/5 dual slope, top FF or A
// R17 - dual slope reverses at top, one tick
// R18 - dual slope clear up-match, set down-match
// R19 - dual slope overflow flag at bottom
// R20 - dual slope full period 510 ticks
// R21 - dual slope extremes give constant levels
// R22 - at top take up-match level for symmetry
// R23 - match flag set after match; write clears
// R24 - counter write wins, blocks next match
// R25 - compares buffered in pwm, direct otherwise
// R26 - reset clears wave output latches
// R27 - buffered compares load at top
module timer_waveform_modes
    import timer_wave_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // timer clock enable
    input wire logic timer_tick_i,
    // software controls
    input wire timer_ctrl_t ctrl_i,
    input wire logic force_match_a_i,
    input wire logic force_match_b_i,
    // counter and compare writes
    input wire logic cnt_wr_i,
    input wire logic [7:0] cnt_wdata_i,
    input wire logic cmp_a_wr_i,
    input wire logic cmp_b_wr_i,
    input wire logic [7:0] cmp_wdata_i,
    // flag clears, write one or interrupt service
    input wire logic ovf_clr_i,
    input wire logic match_a_clr_i,
    input wire logic match_b_clr_i,
    // state outputs
    output logic [7:0] counter_value_o,
    output logic [7:0] compare_value_a_o,
    output timer_flags_t flags_o,
    output logic wave_out_a_o,
    output logic wave_out_b_o
);

    // state
    logic [7:0] cnt_r;                  // counter_value
    logic [7:0] cnt_nxt;
    logic dir_down_r;                   // dual slope direction
    logic dir_down_nxt;
    logic block_r;                      // match blocked after counter write
    logic [7:0] ocr_act_r [CH_NUM];     // active compare values
    logic [7:0] ocr_buf_r [CH_NUM];     // buffered compare values
    logic wave_r [CH_NUM];              // internal wave latches
    logic wave_nxt [CH_NUM];
    timer_flags_t flags_r;
    timer_flags_t flags_nxt;

    // mode decode
    wave_mode_t mode_w;
    logic is_pc_w;
    logic is_fast_w;
    logic is_ctc_w;
    logic is_pwm_w;
    logic top_is_a_w;
    logic [7:0] top_w;
    logic at_top_w;
    logic at_bot_w;
    logic tick_w;
    logic tick_top_w;
    logic ovf_evt_w;
    logic load_buf_w;

    // per channel wires
    logic [1:0] act_w [CH_NUM];
    logic cmp_wr_w [CH_NUM];
    logic frc_w [CH_NUM];
    logic match_w [CH_NUM];
    logic ocr_top_w [CH_NUM];
    logic ocr_bot_w [CH_NUM];

    assign mode_w = ctrl_i.wave_mode_sel;
    assign is_pc_w = (mode_w == WM_PC_FULL) || (mode_w == WM_PC_TOP);         // [R16]
    assign is_fast_w = (mode_w == WM_FAST_FULL) || (mode_w == WM_FAST_TOP);   // [R10]
    assign is_ctc_w = (mode_w == WM_CTC);                                     // [R5]
    assign is_pwm_w = is_pc_w || is_fast_w;
    // compare A sets the top in clear-on-match and the A-topped pwm modes
    assign top_is_a_w = is_ctc_w || (mode_w == WM_PC_TOP) || (mode_w == WM_FAST_TOP);
    assign top_w = top_is_a_w ? ocr_act_r[CH_A] : CNT_MAX;                  // [R10] [R16]
    assign at_top_w = (cnt_r == top_w);
    assign at_bot_w = (cnt_r == CNT_BOTTOM);
    // a counter write wins over any count or clear in its cycle
    assign tick_w = timer_tick_i && !cnt_wr_i;                                // [R24]
    // top event; in dual slope only while counting up
    assign tick_top_w = tick_w && at_top_w && !(is_pc_w && dir_down_r);
    assign load_buf_w = is_pwm_w && tick_top_w;                               // [R27]

    // overflow event per mode
    assign ovf_evt_w = tick_w && (is_pc_w ? (at_bot_w && dir_down_r) :       // [R19]
                       is_fast_w ? at_top_w :                                // [R11]
                       (cnt_r == CNT_MAX));                                  // [R4] [R9]

    // counter next value
    always_comb begin
        cnt_nxt = cnt_r;
        dir_down_nxt = dir_down_r;
        if (cnt_wr_i) begin
            cnt_nxt = cnt_wdata_i;                                            // [R24]
        end else if (timer_tick_i) begin
            if (is_pc_w) begin
                // top and bottom each last exactly one tick
                if (!dir_down_r && at_top_w) begin
                    cnt_nxt = cnt_r - CNT_STEP;                               // [R17]
                    dir_down_nxt = 1'b1;
                end else if (dir_down_r && at_bot_w) begin
                    cnt_nxt = cnt_r + CNT_STEP;                               // [R20]
                    dir_down_nxt = 1'b0;
                end else if (dir_down_r) begin
                    cnt_nxt = cnt_r - CNT_STEP;
                end else begin
                    cnt_nxt = cnt_r + CNT_STEP;
                end
            end else if ((is_fast_w || is_ctc_w) && at_top_w) begin
                cnt_nxt = CNT_BOTTOM;                                         // [R5] [R10] [R14]
            end else begin
                // a top below the count is missed and the count wraps
                cnt_nxt = cnt_r + CNT_STEP;                                   // [R3] [R6]
            end
        end
    end

    // flags: a set in the clear cycle wins
    always_comb begin
        flags_nxt.overflow_flag = ovf_evt_w || (flags_r.overflow_flag && !ovf_clr_i);
        flags_nxt.match_flag_a = match_w[0] || (flags_r.match_flag_a && !match_a_clr_i); // [R7] [R23]
        flags_nxt.match_flag_b = match_w[1] || (flags_r.match_flag_b && !match_b_clr_i); // [R23]
    end

    // counter, direction, block and flags
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= CNT_BOTTOM;
            dir_down_r <= 1'b0;
            block_r <= 1'b0;
            flags_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            dir_down_r <= dir_down_nxt;
            // block lasts until the next tick, even with the timer stopped
            block_r <= cnt_wr_i || (block_r && !timer_tick_i);               // [R24]
            flags_r <= flags_nxt;
        end
    end

    assign cmp_wr_w[0] = cmp_a_wr_i;
    assign cmp_wr_w[1] = cmp_b_wr_i;
    assign act_w[0] = ctrl_i.output_action_sel_a;
    assign act_w[1] = ctrl_i.output_action_sel_b;
    // force only acts outside the pwm modes
    assign frc_w[0] = force_match_a_i && !is_pwm_w;                           // [R2]
    assign frc_w[1] = force_match_b_i && !is_pwm_w;                           // [R2]

    genvar i;
    generate
        for (i = 0; i < CH_NUM; i++) begin : g_ch
            // match is sampled at the tick closing the equal cycle
            assign match_w[i] = tick_w && !block_r && (cnt_r == ocr_act_r[i]); // [R23] [R24]
            assign ocr_top_w[i] = (ocr_act_r[i] == top_w);
            assign ocr_bot_w[i] = (ocr_act_r[i] == CNT_BOTTOM);

            // wave latch next value; action select is read live
            always_comb begin
                wave_nxt[i] = wave_r[i];                                      // [R1]
                if (!is_pwm_w) begin
                    if (match_w[i] || frc_w[i]) begin
                        case (act_w[i])
                            ACT_TOGGLE: wave_nxt[i] = !wave_r[i];            // [R8]
                            ACT_CLEAR: wave_nxt[i] = 1'b0;
                            ACT_SET: wave_nxt[i] = 1'b1;
                            default: wave_nxt[i] = wave_r[i];                // [R1]
                        endcase
                    end
                end else if (act_w[i] == ACT_TOGGLE) begin
                    // toggle only on A with the top bit; reserved on B
                    if ((i == CH_A) && mode_w[2] && match_w[i]) begin
                        wave_nxt[i] = !wave_r[i];                             // [R13]
                    end
                end else if (act_w[i] != ACT_NONE) begin
                    if (is_fast_w) begin
                        // compare at top is ignored, so max gives a constant
                        if (tick_top_w) begin
                            wave_nxt[i] = !act_w[i][0];                       // [R12] [R15]
                        end else if (match_w[i] && !ocr_top_w[i]) begin
                            wave_nxt[i] = act_w[i][0];                        // [R12] [R15]
                        end
                    end else if (tick_top_w) begin
                        // at top force the up-match level unless compare sits at top
                        wave_nxt[i] = ocr_top_w[i] ? !act_w[i][0] : act_w[i][0]; // [R21] [R22]
                    end else if (match_w[i] && !(dir_down_r && ocr_bot_w[i])) begin
                        // a down-match at bottom would break the constant low
                        wave_nxt[i] = dir_down_r ? !act_w[i][0] : act_w[i][0]; // [R18] [R21]
                    end
                end
            end

            // compare registers and wave latch
            always_ff @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    ocr_act_r[i] <= CNT_BOTTOM;
                    ocr_buf_r[i] <= CNT_BOTTOM;
                    wave_r[i] <= 1'b0;                                        // [R26]
                end else begin
                    if (cmp_wr_w[i]) begin
                        ocr_buf_r[i] <= cmp_wdata_i;
                    end
                    // direct write outside pwm, buffered load at top inside
                    if (cmp_wr_w[i] && !is_pwm_w) begin
                        ocr_act_r[i] <= cmp_wdata_i;                          // [R25] [R6]
                    end else if (load_buf_w) begin
                        ocr_act_r[i] <= ocr_buf_r[i];                         // [R25] [R27]
                    end
                    wave_r[i] <= wave_nxt[i];
                end
            end
        end
    endgenerate

    // outputs, all from flip-flops
    assign counter_value_o = cnt_r;
    assign compare_value_a_o = ocr_act_r[CH_A];
    assign flags_o = flags_r;
    assign wave_out_a_o = wave_r[0];
    assign wave_out_b_o = wave_r[1];

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    AST_ACT_NONE_HOLD: assert property ( // [R1]
        (act_w[0] == ACT_NONE) && !is_pwm_w |=> $stable(wave_out_a_o))
        else $error("wave A changed with no action");
    AST_FORCE_SET: assert property ( // [R2]
        force_match_b_i && !is_pwm_w && (act_w[1] == ACT_SET) |=> wave_out_b_o)
        else $error("force did not set wave B");
    AST_NORMAL_WRAP: assert property ( // [R3]
        tick_w && (mode_w == WM_NORMAL) && (cnt_r == CNT_MAX) |=> (cnt_r == CNT_BOTTOM))
        else $error("normal mode did not wrap");
    AST_NORMAL_OVF: assert property ( // [R4]
        tick_w && (mode_w == WM_NORMAL) && (cnt_r == CNT_MAX) |=> flags_o.overflow_flag)
        else $error("overflow not set on wrap");
    // a blocked match still clears the count but leaves the flag alone
    AST_CTC_CLEAR: assert property ( // [R5]
        tick_w && !block_r && is_ctc_w && (cnt_r == ocr_act_r[0])
        |=> (cnt_r == CNT_BOTTOM) && flags_o.match_flag_a)
        else $error("clear on match failed");
    AST_PC_REVERSE: assert property ( // [R17]
        tick_w && is_pc_w && !dir_down_r && at_top_w && !at_bot_w
        |=> dir_down_r && (cnt_r == $past(cnt_r) - CNT_STEP))
        else $error("dual slope did not reverse at top");
    AST_PC_OVF: assert property ( // [R19]
        tick_w && is_pc_w && dir_down_r && at_bot_w |=> flags_o.overflow_flag && !dir_down_r)
        else $error("dual slope overflow missing");
    AST_WRITE_BLOCK: assert property ( // [R24]
        cnt_wr_i ##1 (!cnt_wr_i && timer_tick_i) |-> !match_w[0] && !match_w[1])
        else $error("match not blocked after counter write");
    AST_FLAG_SET_WINS: assert property ( // [R23]
        match_w[1] && match_b_clr_i |=> flags_o.match_flag_b)
        else $error("clear beat a match set");
    AST_FAST_TOP_SET: assert property ( // [R12]
        tick_top_w && is_fast_w && (act_w[0] == ACT_CLEAR) |=> wave_out_a_o ##1 1'b1)
        else $error("fast pwm did not set at top");
    AST_RESET_WAVE: assert property ( // [R26]
        $rose(reset_n_i) |-> !wave_out_a_o && !wave_out_b_o)
        else $error("wave latches not cleared by reset");

    // clear-on-match: a top written below the count is passed over until the wrap
    AST_CTC_MISSED_TOP: assert property ( // [R6]
        tick_w && is_ctc_w && (cnt_r > ocr_act_r[0]) && (cnt_r != CNT_MAX)
        |=> (cnt_r == $past(cnt_r) + CNT_STEP))
        else $error("count cleared although compare lies below it");
    AST_MATCH_FLAG_A: assert property ( // [R7]
        match_w[0] |=> flags_o.match_flag_a)
        else $error("match flag A not set");
    AST_CTC_TOGGLE: assert property ( // [R8]
        match_w[0] && is_ctc_w && (act_w[0] == ACT_TOGGLE) |=> $changed(wave_out_a_o))
        else $error("wave A did not toggle on match");
    AST_CTC_OVF: assert property ( // [R9]
        tick_w && is_ctc_w && (cnt_r == CNT_MAX) |=> flags_o.overflow_flag && (cnt_r == CNT_BOTTOM))
        else $error("clear on match overflow missing");
    // fast pwm: overflow at top, clear on match, reserved toggle and the max extreme
    AST_FAST_OVF: assert property ( // [R11]
        tick_top_w && is_fast_w |=> flags_o.overflow_flag && (cnt_r == CNT_BOTTOM))
        else $error("fast pwm overflow missing at top");
    AST_FAST_MATCH_CLR: assert property ( // [R12]
        match_w[0] && is_fast_w && (act_w[0] == ACT_CLEAR) && !ocr_top_w[0] |=> !wave_out_a_o)
        else $error("fast pwm did not clear on match");
    AST_B_TOGGLE_RESERVED: assert property ( // [R13]
        is_pwm_w && (act_w[1] == ACT_TOGGLE) |=> $stable(wave_out_b_o))
        else $error("reserved toggle moved wave B");
    AST_FAST_MAX_CONST: assert property ( // [R15]
        is_fast_w && ocr_top_w[0] && (act_w[0] == ACT_CLEAR) && wave_out_a_o |=> wave_out_a_o)
        else $error("fast pwm at max not constant");
    // dual slope: matches by direction, the max extreme and symmetry at top
    AST_PC_UP_CLR: assert property ( // [R18]
        match_w[0] && is_pc_w && !dir_down_r && !at_top_w && (act_w[0] == ACT_CLEAR) |=> !wave_out_a_o)
        else $error("dual slope up-match did not clear");
    AST_PC_DOWN_SET: assert property ( // [R18]
        match_w[0] && is_pc_w && dir_down_r && !ocr_bot_w[0] && (act_w[0] == ACT_CLEAR) |=> wave_out_a_o)
        else $error("dual slope down-match did not set");
    AST_PC_MAX_HIGH: assert property ( // [R21]
        tick_top_w && is_pc_w && ocr_top_w[0] && (act_w[0] == ACT_CLEAR) |=> wave_out_a_o)
        else $error("dual slope compare at max not high");
    AST_PC_SYM_TOP: assert property ( // [R22]
        tick_top_w && is_pc_w && !ocr_top_w[0] && (act_w[0] == ACT_CLEAR) |=> !wave_out_a_o)
        else $error("dual slope top did not take up-match level");
    // compare A path: direct outside pwm, buffered load at top inside
    AST_CMP_DIRECT: assert property ( // [R25]
        cmp_a_wr_i && !is_pwm_w |=> (compare_value_a_o == $past(cmp_wdata_i)))
        else $error("direct compare write lost");
    AST_BUF_LOAD: assert property ( // [R27]
        load_buf_w |=> (compare_value_a_o == $past(ocr_buf_r[0])))
        else $error("buffered compare not loaded at top");

    COV_FAST_SPIKE: cover property (tick_top_w && is_fast_w && ocr_bot_w[0]);
    COV_PC_TURN: cover property (tick_top_w && is_pc_w ##[1:300] ovf_evt_w);
    COV_CTC_TOGGLE: cover property (is_ctc_w && match_w[0] && (act_w[0] == ACT_TOGGLE));
    COV_BLOCKED: cover property (block_r && timer_tick_i && (cnt_r == ocr_act_r[0]));
    COV_SET_WINS_B: cover property (match_w[1] && match_b_clr_i);

endmodule

// ---- core/timer_wave_pkg.sv ----
// Purpose: shared constants and types for the 8-bit timer waveform block
// Assumes: one timer tick enable per prescaled timer clock
// Notes: counter width, mode codes and output action codes live here
package timer_wave_pkg;

    localparam int CNT_W = 8;                       // counter and compare width
    localparam logic [7:0] CNT_BOTTOM = 8'h00;      // bottom of every count
    localparam logic [7:0] CNT_MAX = 8'hFF;         // largest count value
    localparam logic [7:0] CNT_STEP = 8'h01;        // one count step
    localparam int CH_A = 0;                        // channel index of A
    localparam int CH_NUM = 2;                      // compare channels

    // wave mode select codes; 4 and 6 behave as normal
    typedef enum logic [2:0] {
        WM_NORMAL = 3'h0,
        WM_PC_FULL = 3'h1,
        WM_CTC = 3'h2,
        WM_FAST_FULL = 3'h3,
        WM_PC_TOP = 3'h5,
        WM_FAST_TOP = 3'h7
    } wave_mode_t;

    // output action select codes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // static controls written by software
    typedef struct packed {
        wave_mode_t wave_mode_sel;
        logic [1:0] output_action_sel_a;
        logic [1:0] output_action_sel_b;
    } timer_ctrl_t;

    // sticky flags shown to software
    typedef struct packed {
        logic overflow_flag;
        logic match_flag_a;
        logic match_flag_b;
    } timer_flags_t;

endpackage

// ---- testbench/tick_source.sv ----
// Purpose: software-side model that hands the timer its prescaled tick enable
// Assumes: one mclk_i domain; run_i is the clock select being non-zero
// Notes: div_p of 1 gives a held-high tick, i.e. no prescaling
`timescale 1ns/1ps
module tick_source #(
    parameter int div_p = 1 // prescale factor
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // control and tick
    input wire logic run_i,
    output logic timer_tick_o
);
    logic [15:0] div_r; // prescale phase counter

    // phase counter runs only while selected, so a stopped timer sees no ticks
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r <= 16'h0000;
        end else if (!run_i || div_r == 16'(div_p - 1)) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    assign timer_tick_o = run_i && (div_r == 16'h0000); // one tick per prescale span
endmodule

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the timer waveform block
// Assumes: tick held high while running, inputs driven 1 ns after the edge
// Notes: each scenario task drives the block and judges what comes back
`timescale 1ns/1ps
module testbench;
    import timer_wave_pkg::*;
    logic mclk_i, reset_n_i, run, tick, fa, fb, cw, cmpa, cmpb, oc, mac, mbc;
    logic [7:0] cwd, cmpd, cnt, cmpv;
    timer_ctrl_t ctrl;
    timer_flags_t fl;
    logic wa, wb;
    int bad_count, checks;

    tick_source #(.div_p(1)) src (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .run_i(run), .timer_tick_o(tick));
    timer_waveform_modes uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .timer_tick_i(tick), .ctrl_i(ctrl),
        .force_match_a_i(fa), .force_match_b_i(fb), .cnt_wr_i(cw), .cnt_wdata_i(cwd), .cmp_a_wr_i(cmpa),
        .cmp_b_wr_i(cmpb), .cmp_wdata_i(cmpd), .ovf_clr_i(oc), .match_a_clr_i(mac), .match_b_clr_i(mbc),
        .counter_value_o(cnt), .compare_value_a_o(cmpv), .flags_o(fl), .wave_out_a_o(wa), .wave_out_b_o(wb));

    // free-running 100 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // compare one value, count it, report a mismatch at once
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // advance n edges, landing just after the edge so outputs are settled
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            #1;
        end
    endtask

    // live controls; channel B stays disconnected
    task automatic mode(input wave_mode_t m, input logic [1:0] act);
        ctrl = '{wave_mode_sel: m, output_action_sel_a: act, output_action_sel_b: ACT_NONE};
    endtask

    // one-cycle counter write with the tick stopped
    task automatic wr_cnt(input logic [7:0] v);
        cw = 1'b1;
        cwd = v;
        cyc(1);
        cw = 1'b0;
    endtask

    // clear the overflow and match A flags in one strobe cycle
    task automatic clr_flags();
        oc = 1'b1;
        mac = 1'b1;
        cyc(1);
        oc = 1'b0;
        mac = 1'b0;
    endtask

    // normal mode: wrap past the maximum and raise overflow as the count hits zero
    task automatic t_normal();
        mode(WM_NORMAL, ACT_NONE);
        wr_cnt(8'hFE);
        check("cnt_write", cnt, 8'hFE);
        run = 1'b1;
        cyc(1);
        check("ovf_before", {7'h00, fl.overflow_flag}, 8'h00);
        cyc(1);
        run = 1'b0;
        check("cnt_wrap", cnt, 8'h00);
        check("ovf_wrap", {7'h00, fl.overflow_flag}, 8'h01);
        clr_flags();
        check("ovf_clear", {7'h00, fl.overflow_flag}, 8'h00);
    endtask

    // strobe a forced match with the given action, tick stopped
    task automatic force_a(input logic [1:0] act, input logic [7:0] exp);
        mode(WM_NORMAL, act);
        fa = 1'b1;
        cyc(1);
        fa = 1'b0;
        cyc(1);
        check("force_wave", {7'h00, wa}, exp);
        check("force_flag", {7'h00, fl.match_flag_a}, 8'h00);
    endtask

    // clear-on-match with toggle: compare A sets the top
    task automatic t_ctc();
        mode(WM_CTC, ACT_TOGGLE);
        cmpa = 1'b1;
        cmpd = 8'h03;
        cyc(1);
        cmpa = 1'b0;
        check("cmp_direct", cmpv, 8'h03);
        wr_cnt(8'h00);
        run = 1'b1;
        cyc(4);
        check("ctc_clear", cnt, 8'h00);
        check("ctc_flag", {7'h00, fl.match_flag_a}, 8'h01);
        check("ctc_tog1", {7'h00, wa}, 8'h01);
        cyc(4);
        run = 1'b0;
        check("ctc_tog2", {7'h00, wa}, 8'h00);
    endtask

    // fast pwm at full top: buffered compare, clear on match, set at top
    task automatic t_fast();
        mode(WM_FAST_FULL, ACT_CLEAR);
        wr_cnt(8'hFD);
        cmpa = 1'b1;
        cmpd = 8'h80;
        cyc(1);
        cmpa = 1'b0;
        check("cmp_buffered", cmpv, 8'h03);
        clr_flags();
        run = 1'b1;
        cyc(3);
        run = 1'b0;
        check("fast_top", cnt, 8'h00);
        check("cmp_loaded", cmpv, 8'h80);
        check("fast_ovf", {7'h00, fl.overflow_flag}, 8'h01);
        check("fast_set", {7'h00, wa}, 8'h01);
        clr_flags();
        run = 1'b1;
        cyc(128);
        check("fast_pre", {7'h00, wa}, 8'h01);
        cyc(1);
        check("fast_clr", {7'h00, wa}, 8'h00);
        check("fast_mflag", {7'h00, fl.match_flag_a}, 8'h01);
        cyc(127);
        run = 1'b0;
        check("fast_period", cnt, 8'h00);
        check("fast_reset", {7'h00, wa}, 8'h01);
    endtask

    // phase correct at full top: one tick at top, symmetry, bottom overflow
    task automatic t_phase();
        mode(WM_PC_FULL, ACT_CLEAR);
        wr_cnt(8'hFE);
        run = 1'b1;
        cyc(1);
        check("pc_top", cnt, 8'hFF);
        cyc(1);
        run = 1'b0;
        check("pc_down", cnt, 8'hFE);
        check("pc_sym", {7'h00, wa}, 8'h00);
        clr_flags();
        run = 1'b1;
        cyc(254);
        check("pc_bottom", cnt, 8'h00);
        check("pc_dnmatch", {7'h00, wa}, 8'h01);
        cyc(1);
        check("pc_ovf", {7'h00, fl.overflow_flag}, 8'h01);
        cyc(255);
        run = 1'b0;
        check("pc_period", cnt, 8'hFE);
        check("pc_upmatch", {7'h00, wa}, 8'h00);
    endtask

    // channel B in normal mode: force, toggle on match, set beating clear, write block
    task automatic t_chan_b();
        ctrl = '{wave_mode_sel: WM_NORMAL, output_action_sel_a: ACT_NONE, output_action_sel_b: ACT_SET};
        fb = 1'b1;
        cyc(1);
        fb = 1'b0;
        check("force_b", {7'h00, wb}, 8'h01);
        ctrl.output_action_sel_b = ACT_TOGGLE;
        cmpb = 1'b1;
        cmpd = 8'h02;
        mbc = 1'b1;
        cyc(1);
        cmpb = 1'b0;
        mbc = 1'b0;
        check("flag_b_clr", {7'h00, fl.match_flag_b}, 8'h00);
        wr_cnt(8'h00);
        run = 1'b1;
        cyc(2);
        mbc = 1'b1;
        cyc(1);
        mbc = 1'b0;
        run = 1'b0;
        check("match_b_tog", {7'h00, wb}, 8'h00);
        check("flag_b_wins", {7'h00, fl.match_flag_b}, 8'h01);
        cyc(1);
        mbc = 1'b1;
        wr_cnt(8'h02);
        mbc = 1'b0;
        run = 1'b1;
        cyc(1);
        run = 1'b0;
        check("blk_cnt", cnt, 8'h03);
        check("blk_wave", {7'h00, wb}, 8'h00);
        check("blk_flag", {7'h00, fl.match_flag_b}, 8'h00);
    endtask

    // verdict and end of run, shared with the watchdog
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: the sequence needs under 1500 cycles
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        bad_count = 0;
        checks = 0;
        {run, fa, fb, cw, cmpa, cmpb, oc, mac, mbc} = '0;
        cwd = 8'h00;
        cmpd = 8'h00;
        mode(WM_NORMAL, ACT_NONE);
        reset_n_i = 1'b0;
        cyc(20);
        reset_n_i = 1'b1;
        cyc(1);
        check("rst_wave", {6'h00, wa, wb}, 8'h00);
        check("rst_cnt", cnt, 8'h00);
        t_normal();
        force_a(ACT_SET, 8'h01);
        force_a(ACT_NONE, 8'h01);
        force_a(ACT_CLEAR, 8'h00);
        t_ctc();
        t_fast();
        t_phase();
        t_chan_b();
        tally_and_finish();
    end
endmodule
